// >>> ppp_assertions.sv
/*
 * ppp_assertions: checker on the pins between programmer and device.
 * assumes: instantiated beside the interface, one clock, sync active-low reset.
 */
module ppp_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic high_volt,
	input wire logic load_strobe_clock,
	input wire logic wr_n,
	input wire logic oe_n,
	input wire logic action_sel_0,
	input wire logic action_sel_1,
	input wire logic page_latch_strobe,
	input wire logic prog_done_flag,
	input wire logic data_prog_oe,
	input wire logic data_dev_oe
);
	// ---------------------------------------------------------------
	// helper counters
	// ---------------------------------------------------------------
	localparam int HV_MIN = ppp_pkg::ENTRY_CYC - 2;
	logic       lsc_r;
	logic       lsc_nxt;
	logic [3:0] tog_r;
	logic [3:0] tog_nxt;
	logic [3:0] wr_r;
	logic [3:0] wr_nxt;
	logic [9:0] hv_r;
	logic [9:0] hv_nxt;
	logic [3:0] pat;
	assign pat = {page_latch_strobe, action_sel_1, action_sel_0, wr_n};
	always_comb begin
		lsc_nxt = load_strobe_clock;
		tog_nxt = tog_r;
		if (!high_volt && load_strobe_clock != lsc_r && tog_r != 4'hf)
			tog_nxt = tog_r + 4'h1;
		wr_nxt = !wr_n ? 4'h0 : ((wr_r == 4'hf) ? wr_r : wr_r + 4'h1);
		hv_nxt = !high_volt ? 10'h000 : ((hv_r == 10'h3ff) ? hv_r : hv_r + 10'h001);
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lsc_r <= 1'b0;
			tog_r <= 4'h0;
			wr_r  <= 4'hf;
			hv_r  <= 10'h000;
		end else begin
			lsc_r <= lsc_nxt;
			tog_r <= tog_nxt;
			wr_r  <= wr_nxt;
			hv_r  <= hv_nxt;
		end
	end
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	bus_release_a: assert property (oe_n [*6] |-> !data_dev_oe)
		else $error("device drives bus with output enable high");
	bus_single_a: assert property (!(data_dev_oe && data_prog_oe))
		else $error("both ends drive the data bus");
	prog_release_a: assert property (!oe_n && !$past(oe_n) |-> !data_prog_oe)
		else $error("programmer drives bus during read");
	load_width_a: assert property ($rose(load_strobe_clock) |=> load_strobe_clock [*2])
		else $error("load strobe too short");
	write_width_a: assert property ($fell(wr_n) |=> !wr_n [*2])
		else $error("write strobe too short");
	busy_cause_a: assert property ($fell(prog_done_flag) |-> wr_r <= 4'h8)
		else $error("busy without a write pulse");
	busy_span_a: assert property (
		$fell(prog_done_flag) |-> !prog_done_flag [*8] ##[1:1000] prog_done_flag)
		else $error("busy period wrong length");
	busy_quiet_a: assert property (!prog_done_flag |-> !$rose(load_strobe_clock))
		else $error("load strobe while busy");
	entry_pattern_a: assert property (
		$rose(high_volt) |-> pat == 4'h0 && $past(pat) == 4'h0 ##1 pat == 4'h0)
		else $error("entry pattern not static around high voltage");
	entry_toggle_a: assert property ($rose(high_volt) |-> tog_r >= ppp_pkg::ENTRY_TOGGLES)
		else $error("too few clock toggles before entry");
	entry_wait_a: assert property ($rose(load_strobe_clock) && high_volt |-> hv_r >= HV_MIN)
		else $error("load too soon after high voltage");
	cover property ($fell(prog_done_flag));
	cover property ($rose(data_dev_oe));
	cover property ($rose(high_volt));
endmodule : ppp_assertions

// >>> ppp_device.sv
/*
 * ppp_device: device end of the parallel program port.
 * assumes: pins are asynchronous to clock; programmer keeps its timing.
 */
module ppp_device (
	input  wire logic       clock,
	input  wire logic       rst_n,
	ppp_if.dev              pins,
	input  wire logic [7:0] fuse_strap,
	output logic            prog_mode,
	output logic            busy,
	output logic [7:0]      lock_bits,
	output logic [7:0]      fuse_low
);
	// ---------------------------------------------------------------
	// synchronisers and edges
	// ---------------------------------------------------------------
	localparam int NS = 7;
	logic [NS-1:0] s1_r, s2_r, s3_r, s_in;
	logic [7:0]    d1_r, d2_r;
	assign s_in = {pins.high_volt, pins.load_strobe_clock, pins.wr_n, pins.oe_n,
		pins.action_sel_0, pins.action_sel_1, pins.page_latch_strobe};
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			d1_r <= '0;
			d2_r <= '0;
		end else begin
			s1_r <= s_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			d1_r <= pins.data_bus;
			d2_r <= d1_r;
		end
	end
	logic hv, lclk, wrn, oen, a0, a1, pl;
	assign {hv, lclk, wrn, oen, a0, a1, pl} = s2_r;
	logic lclk_rise, wr_fall, pl_rise, hv_rise;
	assign lclk_rise = lclk && !s3_r[5];
	assign wr_fall   = !wrn && s3_r[4];
	assign pl_rise   = pl && !s3_r[0];
	assign hv_rise   = hv && !s3_r[6];
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PPP_D_OFF   = 2'b00,
		PPP_D_GUARD = 2'b01,
		PPP_D_READY = 2'b10,
		PPP_D_BUSY  = 2'b11
	} ppp_dstate_e;
	ppp_dstate_e st_r, st_nxt;
	logic [7:0]  cmd_r, cmd_nxt, alo_r, alo_nxt, ahi_r, ahi_nxt, dlo_r, dlo_nxt;
	logic [7:0]  dhi_r, dhi_nxt, lock_r, lock_nxt, fl_r, fl_nxt, fh_r, fh_nxt;
	logic [7:0]  fx_r, fx_nxt, dout_r, dout_nxt;
	logic [7:0]  tmr_r, tmr_nxt;
	logic [2:0]  tog_r, tog_nxt;
	logic        oe_r, oe_nxt, wen_r, wen_nxt, fstrap_r;
	logic [15:0] flash_m [1 << ppp_pkg::FLASH_BITS];
	logic [15:0] page_m  [1 << ppp_pkg::PAGE_BITS];
	logic [7:0]  ee_m    [1 << ppp_pkg::EE_BITS];
	localparam int FLASH_BITS_W = ppp_pkg::FLASH_BITS;
	logic [FLASH_BITS_W-1:0] faddr;
	logic [15:0] addr_w;
	logic        bs1, bs2;
	assign bs1   = pl;
	assign bs2   = a1;
	assign addr_w = {ahi_r, alo_r};
	assign faddr = addr_w[FLASH_BITS_W-1:0];
	function automatic logic is_write(input logic [7:0] c);
		is_write = (c == ppp_pkg::CMD_ERASE) || (c == ppp_pkg::CMD_WR_FUSE) ||
			(c == ppp_pkg::CMD_WR_LOCK) || (c == ppp_pkg::CMD_WR_FLASH) ||
			(c == ppp_pkg::CMD_WR_EEPROM);
	endfunction : is_write
	// entry pins are page latch, action 1, action 0, write
	logic entry_ok;
	assign entry_ok = !pl && !a1 && !a0 && !wrn;
	always_comb begin
		st_nxt = st_r; cmd_nxt = cmd_r; alo_nxt = alo_r; ahi_nxt = ahi_r;
		dlo_nxt = dlo_r; dhi_nxt = dhi_r; lock_nxt = lock_r; fl_nxt = fl_r;
		fh_nxt = fh_r; fx_nxt = fx_r; dout_nxt = dout_r; tmr_nxt = tmr_r;
		tog_nxt = tog_r; oe_nxt = 1'b0; wen_nxt = wen_r;
		case (st_r)
			PPP_D_OFF: begin
				if (!hv && lclk_rise && tog_r != 3'h7) tog_nxt = tog_r + 3'h1;
				if (hv_rise && entry_ok && tog_r >= 3'(ppp_pkg::ENTRY_TOGGLES)) begin
					st_nxt  = PPP_D_GUARD;
					tmr_nxt = 8'(ppp_pkg::SETUP_CYC);
				end
			end
			PPP_D_GUARD: begin
				if (!hv || !entry_ok) begin
					st_nxt  = PPP_D_OFF;
					tog_nxt = 3'h0;
				end else if (tmr_r == 8'h0) st_nxt = PPP_D_READY;
				else tmr_nxt = tmr_r - 8'h1;
			end
			PPP_D_READY: begin
				if (lclk_rise) begin
					case ({a1, a0})
						ppp_pkg::ACT_ADDR: if (bs1) ahi_nxt = d2_r; else alo_nxt = d2_r;
						ppp_pkg::ACT_DATA: if (bs1) dhi_nxt = d2_r; else dlo_nxt = d2_r;
						ppp_pkg::ACT_CMD: begin
							cmd_nxt = d2_r;
							if (d2_r == ppp_pkg::CMD_NOP) wen_nxt = 1'b0;
							else wen_nxt = is_write(d2_r);
						end
						default: ;
					endcase
				end
				if (wr_fall && wen_r) begin
					st_nxt  = PPP_D_BUSY;
					tmr_nxt = 8'(ppp_pkg::PROG_CYC);
					case (cmd_r)
						ppp_pkg::CMD_ERASE: ;
						ppp_pkg::CMD_WR_FUSE: begin
							if (bs1 && !bs2) fh_nxt = dlo_r;
							else if (!bs1 && bs2) fx_nxt = dlo_r;
							else fl_nxt = dlo_r;
						end
						ppp_pkg::CMD_WR_LOCK: lock_nxt = lock_r & dlo_r;
						default: ;
					endcase
				end
				if (!oen) begin
					oe_nxt = 1'b1;
					case (cmd_r)
						ppp_pkg::CMD_RD_FLASH:
							dout_nxt = bs1 ? flash_m[faddr][15:8] : flash_m[faddr][7:0];
						ppp_pkg::CMD_RD_EEPROM: dout_nxt = ee_m[alo_r[ppp_pkg::EE_BITS-1:0]];
						ppp_pkg::CMD_RD_SIG: dout_nxt = ppp_pkg::SIG_ID ^ alo_r;
						ppp_pkg::CMD_RD_FUSE: dout_nxt = !bs2 ? (bs1 ? lock_r : fl_r)
							: (bs1 ? fh_r : fx_r);
						default: dout_nxt = ppp_pkg::ERASED_B;
					endcase
				end
				if (!hv) begin st_nxt = PPP_D_OFF; tog_nxt = 3'h0; end
			end
			PPP_D_BUSY: begin
				if (tmr_r == 8'h0) begin
					st_nxt = PPP_D_READY;
					// locks open only once the erase has finished
					if (cmd_r == ppp_pkg::CMD_ERASE) lock_nxt = ppp_pkg::ERASED_B;
				end else tmr_nxt = tmr_r - 8'h1;
			end
			default: st_nxt = PPP_D_OFF;
		endcase
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= PPP_D_OFF; cmd_r <= '0; alo_r <= '0; ahi_r <= '0; dlo_r <= '0;
			dhi_r <= '0; lock_r <= ppp_pkg::ERASED_B; fl_r <= ppp_pkg::FUSE_RST;
			fh_r <= ppp_pkg::FUSE_RST; fx_r <= ppp_pkg::FUSE_RST; dout_r <= '0;
			tmr_r <= '0; tog_r <= '0; oe_r <= 1'b0; wen_r <= 1'b0;
		end else begin
			st_r <= st_nxt; cmd_r <= cmd_nxt; alo_r <= alo_nxt; ahi_r <= ahi_nxt;
			dlo_r <= dlo_nxt; dhi_r <= dhi_nxt; lock_r <= lock_nxt; fl_r <= fl_nxt;
			fh_r <= fh_nxt; fx_r <= fx_nxt; dout_r <= dout_nxt; tmr_r <= tmr_nxt;
			tog_r <= tog_nxt; oe_r <= oe_nxt; wen_r <= wen_nxt;
		end
	end
	// ---------------------------------------------------------------
	// memories
	// ---------------------------------------------------------------
	logic erase_go, page_go, ee_go;
	assign erase_go = st_r == PPP_D_READY && wr_fall && wen_r && cmd_r == ppp_pkg::CMD_ERASE;
	assign page_go  = st_r == PPP_D_READY && wr_fall && wen_r && cmd_r == ppp_pkg::CMD_WR_FLASH;
	assign ee_go    = st_r == PPP_D_READY && wr_fall && wen_r && cmd_r == ppp_pkg::CMD_WR_EEPROM;
	always_ff @(posedge clock) begin
		fstrap_r <= fh_r[ppp_pkg::KEEP_EE_BIT];
		for (int k = 0; k < (1 << ppp_pkg::PAGE_BITS); k++) begin
			if (erase_go || page_go) page_m[k] <= ppp_pkg::ERASED_W;
		end
		if (st_r == PPP_D_READY && pl_rise && bs1 && cmd_r == ppp_pkg::CMD_WR_FLASH)
			page_m[alo_r[ppp_pkg::PAGE_BITS-1:0]] <= {dhi_r, dlo_r};
		for (int i = 0; i < (1 << ppp_pkg::FLASH_BITS); i++) begin
			if (erase_go) flash_m[i] <= ppp_pkg::ERASED_W;
			else if (page_go && i[FLASH_BITS_W-1:ppp_pkg::PAGE_BITS] ==
				faddr[FLASH_BITS_W-1:ppp_pkg::PAGE_BITS])
				flash_m[i] <= page_m[i % (1 << ppp_pkg::PAGE_BITS)];
		end
		for (int j = 0; j < (1 << ppp_pkg::EE_BITS); j++) begin
			if (erase_go && fstrap_r) ee_m[j] <= ppp_pkg::ERASED_B;
		end
		if (ee_go) ee_m[alo_r[ppp_pkg::EE_BITS-1:0]] <= dlo_r;
	end
	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	logic pdf_r, pm_r, bsy_r;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pdf_r <= 1'b1;
			pm_r  <= 1'b0;
			bsy_r <= 1'b0;
		end else begin
			pdf_r <= (st_nxt != PPP_D_BUSY);
			pm_r  <= (st_nxt == PPP_D_READY) || (st_nxt == PPP_D_BUSY);
			bsy_r <= (st_nxt == PPP_D_BUSY);
		end
	end
	assign pins.prog_done_flag = pdf_r;
	assign pins.data_from_dev  = dout_r;
	assign pins.data_dev_oe    = oe_r;
	assign prog_mode = pm_r;
	assign busy      = bsy_r;
	assign lock_bits = lock_r;
	assign fuse_low  = fl_r;
	logic unused_strap;
	assign unused_strap = ^fuse_strap;
endmodule : ppp_device

// >>> ppp_fifo.sv
/*
 * ppp_fifo: small valid/ready fifo.
 * assumes: single clock, synchronous active-low reset.
 */
module ppp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;
	always_comb begin
		in_ready  = (cnt_r != DEPTH[AW:0]);
		out_valid = (cnt_r != '0);
		out_data  = mem_r[rp_r];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wp_nxt    = push ? wp_r + 1'b1 : wp_r;
		rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule : ppp_fifo

// >>> ppp_if.sv
/*
 * ppp_if: pins between programmer and device.
 * assumes: testbench resolves the data bus from the two enables.
 */
interface ppp_if;
	logic       high_volt;
	logic       load_strobe_clock;
	logic       wr_n;
	logic       oe_n;
	logic       action_sel_0;
	logic       action_sel_1;
	logic       page_latch_strobe;
	logic       prog_done_flag;
	logic [7:0] data_from_prog;
	logic       data_prog_oe;
	logic [7:0] data_from_dev;
	logic       data_dev_oe;
	logic [7:0] data_bus;
	modport dev (
		input  high_volt, load_strobe_clock, wr_n, oe_n, action_sel_0, action_sel_1,
		input  page_latch_strobe, data_bus,
		output prog_done_flag, data_from_dev, data_dev_oe
	);
	modport prog (
		output high_volt, load_strobe_clock, wr_n, oe_n, action_sel_0, action_sel_1,
		output page_latch_strobe, data_from_prog, data_prog_oe,
		input  prog_done_flag, data_bus
	);
endinterface : ppp_if

// >>> ppp_pkg.sv
/*
 * ppp_pkg: constants for the parallel program port, both ends.
 * assumes: one 10 MHz clock per end, synchronous active-low reset.
 */
// Contract
// - programmer holds each strobe at least 250 ns
// - load strobe action code: address, data, command, idle
// - write or read strobe runs loaded command
// - nine command bytes decoded by device
// - ready output low while busy, high otherwise
// - data bus driven only while output enable low
// - entry: reset low, six clock toggles; device counts six rising edges of load strobe instead
// - entry pins 0000 for 100 ns before high voltage
// - entry pins change within 100 ns: entry refused
// - command and address kept across operations
// - programmer may skip writing 0xff after erase
// - erase clears memories, locks; fuse may keep eeprom
// - programmer erases before reprogramming
// - erase: command load, write pulse, wait ready
// - flash words collected in a page buffer
// - address low/high selected by byte select 1
// - data low/high selected by byte select 1
// - page latch with byte select 1 stores word
// - low address bits word, upper bits page
// - byte selects share pins with action bit, latch
// - write pulse commits page, ready low meanwhile
// - command zero clears write controls
package ppp_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS        = 100;
	localparam int STROBE_NS     = 250;
	localparam int SETUP_NS      = 100;
	localparam int ENTRY_WAIT_US = 50;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ENTRY_CYC     = (ENTRY_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ENTRY_TOGGLES = 6;
	localparam int PROG_CYC      = 20;
	// ---------------------------------------------------------------
	// action codes and commands
	// ---------------------------------------------------------------
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	localparam logic [7:0] CMD_NOP       = 8'h00;
	localparam logic [7:0] CMD_ERASE     = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
	localparam logic [7:0] CMD_RD_SIG    = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
	// ---------------------------------------------------------------
	// memory shape
	// ---------------------------------------------------------------
	localparam int PAGE_BITS  = 6;
	localparam int FLASH_BITS = 8;
	localparam int EE_BITS    = 6;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0]  ERASED_B  = 8'hff;
	localparam logic [15:0] ERASED_W  = 16'hffff;
	localparam logic [7:0]  FUSE_RST  = 8'hff;
	localparam int          KEEP_EE_BIT = 3;
	// arbitrary identity value, not a real part
	localparam logic [7:0]  SIG_ID    = 8'h5a;
	typedef enum logic [1:0] {
		PPP_OP_NONE  = 2'b00,
		PPP_OP_WRITE = 2'b01,
		PPP_OP_READ  = 2'b10
	} ppp_op_e;
endpackage : ppp_pkg

// >>> ppp_programmer.sv
/*
 * ppp_programmer: programmer end; takes requests from a fifo.
 * assumes: user word {kind, bs1, action, data}; kind 0 load, 1 write, 2 read.
 */
module ppp_programmer (
	input  wire logic        clock,
	input  wire logic        rst_n,
	ppp_if.prog              pins,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [15:0] req_data,
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output logic             entered
);
	logic        f_valid, f_ready;
	logic [15:0] f_data;
	ppp_fifo #(.WIDTH(16), .DEPTH(ppp_pkg::FIFO_DEPTH)) u_fifo (
		.clock(clock), .rst_n(rst_n), .in_valid(req_valid), .in_ready(req_ready),
		.in_data(req_data), .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data));
	logic rdy1_r, rdy2_r;
	always_ff @(posedge clock) begin
		if (!rst_n) begin rdy1_r <= 1'b0; rdy2_r <= 1'b0; end
		else begin rdy1_r <= pins.prog_done_flag; rdy2_r <= rdy1_r; end
	end
	typedef enum logic [2:0] {
		PPP_P_TOG = 3'b000, PPP_P_SET = 3'b001, PPP_P_WAIT = 3'b010,
		PPP_P_IDLE = 3'b011, PPP_P_HI = 3'b100, PPP_P_LO = 3'b101, PPP_P_BUSY = 3'b110
	} ppp_pstate_e;
	ppp_pstate_e st_r, st_nxt;
	logic [9:0]  t_r, t_nxt;
	logic [15:0] w_r, w_nxt;
	logic        clk_r, clk_nxt, hv_r, hv_nxt, wr_r, wr_nxt, oe_r, oe_nxt;
	logic [7:0]  rd_r, rd_nxt;
	logic        rv_r, rv_nxt;
	always_comb begin
		st_nxt = st_r; t_nxt = t_r; w_nxt = w_r; clk_nxt = clk_r; hv_nxt = hv_r;
		wr_nxt = wr_r; oe_nxt = oe_r; rd_nxt = rd_r; rv_nxt = 1'b0; f_ready = 1'b0;
		case (st_r)
			PPP_P_TOG: begin
				t_nxt = t_r + 10'h1;
				if (t_r % 10'(ppp_pkg::STROBE_CYC + 1) == 10'(ppp_pkg::STROBE_CYC))
					clk_nxt = ~clk_r;
				if (t_r == 10'(2 * ppp_pkg::ENTRY_TOGGLES * (ppp_pkg::STROBE_CYC + 1))) begin
					st_nxt = PPP_P_SET; t_nxt = '0; clk_nxt = 1'b0;
				end
			end
			PPP_P_SET: begin
				wr_nxt = 1'b0;
				t_nxt  = t_r + 10'h1;
				if (t_r == 10'(ppp_pkg::SETUP_CYC)) begin
					hv_nxt = 1'b1; st_nxt = PPP_P_WAIT; t_nxt = '0;
				end
			end
			PPP_P_WAIT: begin
				t_nxt = t_r + 10'h1;
				if (t_r == 10'(ppp_pkg::ENTRY_CYC)) begin
					st_nxt = PPP_P_IDLE; wr_nxt = 1'b1;
				end
			end
			PPP_P_IDLE: if (f_valid) begin
				f_ready = 1'b1; w_nxt = f_data; t_nxt = '0; st_nxt = PPP_P_HI;
				case (f_data[15:14])
					2'h1: wr_nxt = 1'b0;
					2'h2: oe_nxt = 1'b0;
					default: clk_nxt = 1'b1;
				endcase
			end
			PPP_P_HI: begin
				t_nxt = t_r + 10'h1;
				if (t_r == 10'(ppp_pkg::STROBE_CYC + 2)) begin
					if (!oe_r) begin rd_nxt = pins.data_bus; rv_nxt = 1'b1; end
					clk_nxt = 1'b0; wr_nxt = 1'b1; oe_nxt = 1'b1;
					t_nxt = '0; st_nxt = PPP_P_LO;
				end
			end
			PPP_P_LO: begin
				t_nxt = t_r + 10'h1;
				if (t_r == 10'(ppp_pkg::STROBE_CYC + 2))
					st_nxt = (w_r[15:14] == 2'h1) ? PPP_P_BUSY : PPP_P_IDLE;
			end
			PPP_P_BUSY: if (rdy2_r) st_nxt = PPP_P_IDLE;
			default: st_nxt = PPP_P_TOG;
		endcase
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= PPP_P_TOG; t_r <= '0; w_r <= '0; clk_r <= 1'b0; hv_r <= 1'b0;
			wr_r <= 1'b1; oe_r <= 1'b1; rd_r <= '0; rv_r <= 1'b0;
		end else begin
			st_r <= st_nxt; t_r <= t_nxt; w_r <= w_nxt; clk_r <= clk_nxt; hv_r <= hv_nxt;
			wr_r <= wr_nxt; oe_r <= oe_nxt; rd_r <= rd_nxt; rv_r <= rv_nxt;
		end
	end
	logic in_entry;
	assign in_entry = (st_r == PPP_P_TOG) || (st_r == PPP_P_SET) || (st_r == PPP_P_WAIT);
	assign pins.high_volt         = hv_r;
	assign pins.load_strobe_clock = clk_r;
	assign pins.wr_n              = wr_r;
	assign pins.oe_n              = oe_r;
	assign pins.action_sel_0      = in_entry ? 1'b0 : w_r[8];
	assign pins.action_sel_1      = in_entry ? 1'b0 : w_r[9];
	assign pins.page_latch_strobe = in_entry ? 1'b0 : w_r[13];
	assign pins.data_from_prog    = w_r[7:0];
	assign pins.data_prog_oe      = (w_r[15:14] != 2'h2) && !in_entry;
	assign rd_valid = rv_r;
	assign rd_data  = rd_r;
	assign entered  = (st_r != PPP_P_TOG) && (st_r != PPP_P_SET) && (st_r != PPP_P_WAIT);
endmodule : ppp_programmer

// >>> tb_parallel_program_port.sv
/*
 * tb_parallel_program_port: both ends joined, plus a lone device for refused entry.
 * assumes: programmer enters programming mode by itself after reset.
 */
module tb_parallel_program_port;
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// signals and design
	// ---------------------------------------------------------------
	logic        clock     = 1'b0;
	logic        rst_n     = 1'b0;
	logic        req_valid = 1'b0;
	logic [15:0] req_data  = 16'h0000;
	logic [7:0]  float_r   = 8'h5a;
	logic        saw_full  = 1'b0;
	logic        req_ready;
	logic        rd_valid;
	logic [7:0]  rd_data;
	logic        entered;
	logic        prog_mode;
	logic        prog_mode_b;
	logic        busy;
	logic [7:0]  lock_bits;
	logic [7:0]  fuse_low;
	int          mismatches = 0;
	int          n_checks   = 0;
	ppp_if pins();
	ppp_if pins_b();
	assign pins.data_bus = pins.data_dev_oe ? pins.data_from_dev :
		(pins.data_prog_oe ? pins.data_from_prog : float_r);
	assign pins_b.data_bus = pins_b.data_dev_oe ? pins_b.data_from_dev : float_r;
	always #50 clock = ~clock;
	always @(posedge clock) float_r <= ~float_r;
	ppp_programmer u_ppp_programmer (.clock(clock), .rst_n(rst_n), .pins(pins),
		.req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .entered(entered));
	ppp_device u_ppp_device (.clock(clock), .rst_n(rst_n), .pins(pins), .fuse_strap(8'hff),
		.prog_mode(prog_mode), .busy(busy), .lock_bits(lock_bits), .fuse_low(fuse_low));
	ppp_device u_ppp_device_b (.clock(clock), .rst_n(rst_n), .pins(pins_b),
		.fuse_strap(8'hff), .prog_mode(prog_mode_b), .busy(), .lock_bits(), .fuse_low());
	ppp_assertions u_ppp_assertions (.clock(clock), .rst_n(rst_n),
		.high_volt(pins.high_volt), .load_strobe_clock(pins.load_strobe_clock),
		.wr_n(pins.wr_n), .oe_n(pins.oe_n), .action_sel_0(pins.action_sel_0),
		.action_sel_1(pins.action_sel_1), .page_latch_strobe(pins.page_latch_strobe),
		.prog_done_flag(pins.prog_done_flag), .data_prog_oe(pins.data_prog_oe),
		.data_dev_oe(pins.data_dev_oe));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task complete_run();
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic push(input logic [15:0] w);
		@(posedge clock);
		req_valid <= 1'b1;
		req_data  <= w;
		do begin
			@(posedge clock);
			if (req_ready !== 1'b1) saw_full = 1'b1;
		end while (req_ready !== 1'b1);
		req_valid <= 1'b0;
	endtask : push
	task automatic ld(input logic [1:0] act, input logic bs1, input logic [7:0] d);
		push({2'h0, bs1, 3'h0, act, d});
	endtask : ld
	task automatic cmd(input logic [7:0] c);
		ld(ppp_pkg::ACT_CMD, 1'b0, c);
	endtask : cmd
	task automatic addr(input logic bs1, input logic [7:0] d);
		ld(ppp_pkg::ACT_ADDR, bs1, d);
	endtask : addr
	task automatic dat(input logic bs1, input logic [7:0] d);
		ld(ppp_pkg::ACT_DATA, bs1, d);
	endtask : dat
	task automatic latch();
		ld(ppp_pkg::ACT_IDLE, 1'b0, 8'h00);
		ld(ppp_pkg::ACT_IDLE, 1'b1, 8'h00);
		ld(ppp_pkg::ACT_IDLE, 1'b0, 8'h00);
	endtask : latch
	task automatic wr(input logic busy_exp);
		int i;
		push({2'h1, 14'h0000});
		for (i = 0; i < 3000 && pins.wr_n !== 1'b0; i++) @(posedge clock);
		chk({7'h0, pins.wr_n}, 8'h00);
		for (i = 0; i < 40 && pins.prog_done_flag === 1'b1; i++) @(posedge clock);
		chk({7'h0, pins.prog_done_flag}, {7'h0, !busy_exp});
		if (busy_exp) begin
			chk({7'h0, busy}, 8'h01);
			for (i = 0; i < 3000 && pins.prog_done_flag !== 1'b1; i++) @(posedge clock);
			chk({7'h0, pins.prog_done_flag}, 8'h01);
			chk({7'h0, i >= ppp_pkg::PROG_CYC - 4}, 8'h01);
		end
	endtask : wr
	task automatic rd(input logic bs1, input logic [7:0] exp);
		int i;
		push({2'h2, bs1, 13'h0000});
		for (i = 0; i < 3000 && rd_valid !== 1'b1; i++) @(posedge clock);
		chk({7'h0, rd_valid}, 8'h01);
		chk(rd_data, exp);
	endtask : rd
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_entry_refused();
		repeat (12) begin
			@(posedge clock);
			pins_b.load_strobe_clock <= ~pins_b.load_strobe_clock;
			repeat (3) @(posedge clock);
		end
		repeat (3) @(posedge clock);
		pins_b.high_volt    <= 1'b1;
		@(posedge clock);
		pins_b.action_sel_0 <= 1'b1;
		repeat (700) @(posedge clock);
		chk({7'h0, prog_mode_b}, 8'h00);
		chk({7'h0, pins_b.data_dev_oe}, 8'h00);
	endtask : t_entry_refused
	task automatic t_entry();
		int i;
		for (i = 0; i < 3000 && entered !== 1'b1; i++) @(posedge clock);
		chk({7'h0, entered}, 8'h01);
		chk({7'h0, prog_mode}, 8'h01);
		chk({7'h0, pins.prog_done_flag}, 8'h01);
		chk({7'h0, pins.data_dev_oe}, 8'h00);
	endtask : t_entry
	task automatic t_fifo_full();
		saw_full = 1'b0;
		repeat (24) ld(ppp_pkg::ACT_IDLE, 1'b0, 8'h00);
		chk({7'h0, saw_full}, 8'h01);
	endtask : t_fifo_full
	task automatic t_fuse_lock();
		cmd(ppp_pkg::CMD_WR_FUSE);
		dat(1'b0, 8'h5c);
		wr(1'b1);
		chk(fuse_low, 8'h5c);
		cmd(ppp_pkg::CMD_WR_LOCK);
		dat(1'b0, 8'hfc);
		wr(1'b1);
		chk(lock_bits, 8'hfc);
	endtask : t_fuse_lock
	task automatic t_erase();
		cmd(ppp_pkg::CMD_ERASE);
		wr(1'b1);
		chk(lock_bits, 8'hff);
		chk(fuse_low, 8'h5c);
		cmd(ppp_pkg::CMD_RD_FUSE);
		rd(1'b0, 8'h5c);
		rd(1'b1, 8'hff);
	endtask : t_erase
	task automatic t_flash();
		// erased words are left alone
		cmd(ppp_pkg::CMD_WR_FLASH);
		addr(1'b1, 8'h00);
		addr(1'b0, 8'h47);
		dat(1'b0, 8'h34);
		dat(1'b1, 8'h12);
		latch();
		addr(1'b0, 8'h48);
		dat(1'b0, 8'h78);
		dat(1'b1, 8'h56);
		latch();
		wr(1'b1);
		cmd(ppp_pkg::CMD_RD_FLASH);
		addr(1'b0, 8'h47);
		rd(1'b0, 8'h34);
		rd(1'b1, 8'h12);
		addr(1'b0, 8'h48);
		rd(1'b0, 8'h78);
		rd(1'b1, 8'h56);
		addr(1'b0, 8'h07);
		rd(1'b0, 8'hff);
	endtask : t_flash
	task automatic t_eeprom();
		cmd(ppp_pkg::CMD_WR_EEPROM);
		addr(1'b0, 8'h05);
		dat(1'b0, 8'h3c);
		latch();
		wr(1'b1);
		cmd(ppp_pkg::CMD_RD_EEPROM);
		rd(1'b0, 8'h3c);
		addr(1'b0, 8'h06);
		rd(1'b0, 8'hff);
		cmd(ppp_pkg::CMD_RD_SIG);
		addr(1'b0, 8'h00);
		rd(1'b0, ppp_pkg::SIG_ID);
	endtask : t_eeprom
	task automatic t_refused();
		cmd(ppp_pkg::CMD_NOP);
		wr(1'b0);
		cmd(ppp_pkg::CMD_RD_FLASH);
		wr(1'b0);
	endtask : t_refused
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		pins_b.high_volt         = 1'b0;
		pins_b.load_strobe_clock = 1'b0;
		pins_b.wr_n              = 1'b0;
		pins_b.oe_n              = 1'b1;
		pins_b.action_sel_0      = 1'b0;
		pins_b.action_sel_1      = 1'b0;
		pins_b.page_latch_strobe = 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_entry_refused();
		t_entry();
		t_fifo_full();
		t_fuse_lock();
		t_erase();
		t_flash();
		t_eeprom();
		t_refused();
		complete_run();
	end
	initial begin
		#4000000;
		mismatches++;
		complete_run();
	end
endmodule : tb_parallel_program_port
